//--- verilog/sar_pkg.sv
/*
 Constants, state types and timing counts shared by both ends of the
 converter's serial readout link. Assumes a single 40 MHz system clock.
*/
// Summary of operation
// - Host holds frame sync high for chip-select framing
// - Chip-select fall presents the result MSB
// - Later bits shift on rises after a fall
// - Chip-select re-fall mid frame restarts from MSB
// - Frame-sync rise presents the result MSB
// - Frame-sync mode shifts after its fall, fall, rise; the device also arms on a serial clock fall while frame sync is still high
// - Frame sync high at busy fall reloads MSB
// - Frame-sync rise mid frame restarts the frame
// - Conversion completes within the longest conversion time
// - Only start and select steer conversion; internal timing (here power down also ends a conversion)
// - Format select picks straight binary or two's complement
// - Full and mid scale give the tabled codes
// - Result swaps at busy fall; host avoids framing there
// - Host keeps serial clock quiet during conversion
// - Power down releases serial out, resumes on release
// - Start low at end of conversion enters nap
// - Qualified start follows start only while selected
// - Start fall converts; fall mid conversion aborts
// - Start high and selected begins sampling, else wait
package sar_pkg;
    localparam int RES_W = 18;
    localparam logic [RES_W-1:0] ABORT_CODE = 18'h3fc00;
    localparam logic [4:0] LAST_BIT = 5'h11;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam real CONV_TIME_US = 1.16;
    localparam int CONV_CYC = int'($floor(CONV_TIME_US * CLK_MHZ));
    localparam real SCLK_HALF_NS = 100.0;
    localparam int SCLK_HALF_CYC = int'($floor(SCLK_HALF_NS * CLK_MHZ / 1000.0));
    localparam int CTL_HOLD_CYC = 4;
    // ------------------------------------------------------------
    // Host register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_DATA = 4'hc;
    localparam int CTRL_FS_MODE = 0;
    localparam int CTRL_PDOWN = 1;
    localparam int CMD_CONV = 0;
    localparam int CMD_READ = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_VALID = 2;
    typedef enum logic [2:0] {ST_WAIT, ST_SAMPLE, ST_CONVERT, ST_NAP, ST_PWRDN} sar_dev_st_e;
    typedef enum logic [2:0] {H_IDLE, H_CV_SET, H_CV_LOW, H_CV_REL, H_RD_WAIT, H_RD_SYNC,
        H_RD_CLK} sar_host_st_e;
endpackage

//--- verilog/sar_if.sv
/*
 Pin-level link between converter and host controller.
 Assumes the bench resolves sdo from sdo_oe; no clocking block.
*/
interface sar_if;
    logic cs_n;
    logic frame_sync;
    logic sclk;
    logic conv_start;
    logic power_down_pin;
    logic busy;
    logic sdo;
    logic sdo_oe;
    modport dev (input cs_n, frame_sync, sclk, conv_start, power_down_pin,
        output busy, sdo, sdo_oe);
    modport host (output cs_n, frame_sync, sclk, conv_start, power_down_pin,
        input busy, sdo, sdo_oe);
endinterface

//--- verilog/sar_dev.sv
/*
 Converter end: conversion sequencing, result latch, output coding and
 the serial readout in both framing modes.
 Assumes all link pins are asynchronous to mclk; adc_code models the
 comparator result in straight binary.
*/
module sar_dev
    import sar_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    sar_if.dev lnk,
    input wire logic [sar_pkg::RES_W-1:0] adc_code,
    input wire logic format_select,
    output logic napping,
    output logic powered_down
);
    import sar_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Order: cs_n, frame_sync, sclk, conv_start, power_down_pin
    logic [4:0] sy1_ff;
    logic [4:0] sy2_ff;
    logic [4:0] sy3_ff;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            // Idle pin levels, power down released: no false edge or power down after reset
            sy1_ff <= 5'h1e;
            sy2_ff <= 5'h1e;
            sy3_ff <= 5'h1e;
        end
        else
        begin
            sy1_ff <= {lnk.cs_n, lnk.frame_sync, lnk.sclk, lnk.conv_start,
                lnk.power_down_pin};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
        end
    end

    logic cs_low;
    logic cs_fall;
    logic fs_s;
    logic fs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic conv_s;
    logic pd_s;

    assign cs_low = ~sy2_ff[4];
    assign cs_fall = sy3_ff[4] & ~sy2_ff[4];
    assign fs_s = sy2_ff[3];
    assign fs_rise = sy2_ff[3] & ~sy3_ff[3];
    assign sclk_rise = sy2_ff[2] & ~sy3_ff[2];
    assign sclk_fall = sy3_ff[2] & ~sy2_ff[2];
    assign conv_s = sy2_ff[1];
    assign pd_s = sy2_ff[0];

    // ------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------
    sar_dev_st_e state_ff;
    sar_dev_st_e nxt_state;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic qual_ff;
    logic nxt_qual;
    logic [RES_W-1:0] result_ff;
    logic [RES_W-1:0] nxt_result;
    logic busy_ff;
    logic [RES_W-1:0] coded;
    logic qual_fall;
    logic busy_fall;

    // Two's complement of an offset-binary span is the MSB flipped
    assign coded = {adc_code[RES_W-1] ^ format_select, adc_code[RES_W-2:0]};

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_result = result_ff;
        nxt_qual = cs_low ? conv_s : qual_ff;
        qual_fall = qual_ff & ~nxt_qual;
        case (state_ff)
            ST_WAIT, ST_NAP:
            begin
                if (nxt_qual && cs_low)
                begin
                    nxt_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                if (qual_fall)
                begin
                    nxt_state = ST_CONVERT;
                    nxt_cnt = 6'h0;
                end
            end
            ST_CONVERT:
            begin
                nxt_cnt = cnt_ff + 6'h1;
                if (qual_fall)
                begin
                    nxt_state = ST_WAIT;
                    nxt_result = ABORT_CODE;
                end
                else if (cnt_ff == 6'(CONV_CYC - 1))
                begin
                    nxt_result = coded;
                    if (nxt_qual && cs_low)
                    begin
                        nxt_state = ST_SAMPLE;
                    end
                    else if (!nxt_qual)
                    begin
                        nxt_state = ST_NAP;
                    end
                    else
                    begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_WAIT;
            end
        endcase
        if (pd_s)
        begin
            nxt_state = ST_PWRDN;
        end
        busy_fall = (state_ff == ST_CONVERT) && (nxt_state != ST_CONVERT);
    end

    // ------------------------------------------------------------
    // Serial readout
    // ------------------------------------------------------------
    logic [RES_W-1:0] shift_ff;
    logic [RES_W-1:0] nxt_shift;
    logic [4:0] bits_ff;
    logic [4:0] nxt_bits;
    logic armed_ff;
    logic nxt_armed;
    logic act_ff;
    logic nxt_act;
    logic cs_mode;

    // Frame sync held high selects chip-select framing
    assign cs_mode = fs_s;

    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_bits = bits_ff;
        nxt_armed = armed_ff;
        nxt_act = act_ff;
        if (nxt_state == ST_PWRDN)
        begin
            nxt_act = 1'b0;
            nxt_armed = 1'b0;
        end
        else if ((cs_mode && cs_fall) || fs_rise)
        begin
            // A new frame always wins over one in flight
            nxt_shift = nxt_result;
            nxt_bits = 5'h0;
            nxt_armed = 1'b0;
            nxt_act = 1'b1;
        end
        else if (busy_fall && fs_s)
        begin
            nxt_shift = nxt_result;
            nxt_bits = 5'h0;
            nxt_armed = 1'b0;
            nxt_act = 1'b1;
        end
        else if (cs_mode && !cs_low)
        begin
            nxt_act = 1'b0;
            nxt_armed = 1'b0;
        end
        else if (act_ff && cs_low)
        begin
            if (sclk_fall && (cs_mode || !fs_s))
            begin
                nxt_armed = 1'b1;
            end
            else if (sclk_rise && armed_ff)
            begin
                nxt_shift = {shift_ff[RES_W-2:0], 1'b0};
                nxt_bits = bits_ff + 5'h1;
                // No data is promised past the last bit of a frame
                if (bits_ff == LAST_BIT)
                begin
                    nxt_act = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    logic oe_ff;
    logic nap_ff;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_WAIT;
            cnt_ff <= 6'h0;
            qual_ff <= 1'b1;
            result_ff <= '0;
            busy_ff <= 1'b0;
            shift_ff <= '0;
            bits_ff <= 5'h0;
            armed_ff <= 1'b0;
            act_ff <= 1'b0;
            oe_ff <= 1'b0;
            nap_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            qual_ff <= nxt_qual;
            result_ff <= nxt_result;
            busy_ff <= (nxt_state == ST_CONVERT);
            shift_ff <= nxt_shift;
            bits_ff <= nxt_bits;
            armed_ff <= nxt_armed;
            act_ff <= nxt_act;
            oe_ff <= (nxt_state != ST_PWRDN);
            nap_ff <= (nxt_state == ST_NAP);
        end
    end

    assign lnk.busy = busy_ff;
    assign lnk.sdo = shift_ff[RES_W-1];
    assign lnk.sdo_oe = oe_ff;
    assign napping = nap_ff;
    assign powered_down = ~oe_ff;
endmodule

//--- verilog/sar_host.sv
/*
 Host end: software register port, conversion start sequencing and a
 serial clock made by dividing mclk.
 Assumes busy and sdo are asynchronous to mclk.
*/
module sar_host
    import sar_pkg::*;
#(
    parameter int HALF_CYC = sar_pkg::SCLK_HALF_CYC
)
(
    input wire logic mclk,
    input wire logic nrst,
    sar_if.host lnk,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    import sar_pkg::*;

    logic [1:0] bsy_sy_ff;
    logic [1:0] sdo_sy_ff;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            bsy_sy_ff <= 2'h0;
            sdo_sy_ff <= 2'h0;
        end
        else
        begin
            bsy_sy_ff <= {bsy_sy_ff[0], lnk.busy};
            sdo_sy_ff <= {sdo_sy_ff[0], lnk.sdo};
        end
    end

    // ------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------
    sar_host_st_e st_ff, nxt_st;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [4:0] bits_ff, nxt_bits;
    logic [RES_W-1:0] sh_ff, nxt_sh, data_ff, nxt_data;
    logic valid_ff, nxt_valid;
    logic cs_ff, nxt_cs, fsp_ff, nxt_fsp, sclk_ff, nxt_sclk, conv_ff, nxt_conv;
    logic [31:0] rdata_ff, nxt_rdata;
    logic fs_mode;
    logic half_done;

    assign fs_mode = ctrl_ff[CTRL_FS_MODE];
    assign half_done = (cnt_ff == 8'(HALF_CYC - 1));

    always_comb
    begin
        nxt_st = st_ff;
        nxt_ctrl = ctrl_ff;
        nxt_cnt = cnt_ff + 8'h1;
        nxt_bits = bits_ff;
        nxt_sh = sh_ff;
        nxt_data = data_ff;
        nxt_valid = valid_ff;
        nxt_cs = cs_ff;
        nxt_fsp = fsp_ff;
        nxt_sclk = sclk_ff;
        nxt_conv = conv_ff;
        nxt_rdata = 32'h0;
        if (wr && addr == REG_CTRL)
        begin
            nxt_ctrl = wdata[1:0];
        end
        if (rd)
        begin
            if (addr == REG_CTRL)
            begin
                nxt_rdata = {30'h0, ctrl_ff};
            end
            else if (addr == REG_STAT)
            begin
                nxt_rdata = {29'h0, valid_ff, st_ff != H_IDLE, bsy_sy_ff[1]};
            end
            else if (addr == REG_DATA)
            begin
                nxt_rdata = {14'h0, data_ff};
                nxt_valid = 1'b0;
            end
        end
        case (st_ff)
            H_IDLE:
            begin
                nxt_cnt = 8'h0;
                if (wr && addr == REG_CMD && wdata[CMD_CONV])
                begin
                    nxt_st = H_CV_SET;
                    nxt_cs = 1'b0;
                end
                else if (wr && addr == REG_CMD && wdata[CMD_READ])
                begin
                    nxt_st = H_RD_WAIT;
                end
            end
            H_CV_SET, H_CV_LOW, H_CV_REL:
            begin
                // Start is only seen while selected, so select brackets it
                if (cnt_ff == 8'(CTL_HOLD_CYC - 1))
                begin
                    nxt_cnt = 8'h0;
                    nxt_st = (st_ff == H_CV_SET) ? H_CV_LOW :
                        (st_ff == H_CV_LOW) ? H_CV_REL : H_IDLE;
                    nxt_conv = (st_ff != H_CV_SET);
                    nxt_cs = (st_ff == H_CV_REL) ? 1'b1 : 1'b0;
                end
            end
            H_RD_WAIT:
            begin
                nxt_cnt = 8'h0;
                // Never frame during conversion or at the busy fall
                if (!bsy_sy_ff[1])
                begin
                    nxt_st = H_RD_SYNC;
                    nxt_cs = 1'b0;
                    nxt_fsp = 1'b1;
                    nxt_bits = 5'h0;
                end
            end
            H_RD_SYNC:
            begin
                if (half_done)
                begin
                    nxt_cnt = 8'h0;
                    nxt_fsp = 1'b0;
                    nxt_st = H_RD_CLK;
                end
            end
            default:
            begin
                if (half_done)
                begin
                    nxt_cnt = 8'h0;
                    nxt_sclk = ~sclk_ff;
                    if (!sclk_ff)
                    begin
                        // Bit is stable here, before the device shifts
                        nxt_sh = {sh_ff[RES_W-2:0], sdo_sy_ff[1]};
                        nxt_bits = bits_ff + 5'h1;
                        if (bits_ff == LAST_BIT)
                        begin
                            nxt_st = H_IDLE;
                            nxt_cs = 1'b1;
                            nxt_data = {sh_ff[RES_W-2:0], sdo_sy_ff[1]};
                            nxt_valid = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= H_IDLE;
            ctrl_ff <= 2'h0;
            cnt_ff <= 8'h0;
            bits_ff <= 5'h0;
            sh_ff <= '0;
            data_ff <= '0;
            valid_ff <= 1'b0;
            cs_ff <= 1'b1;
            fsp_ff <= 1'b0;
            sclk_ff <= 1'b1;
            conv_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end
        else
        begin
            st_ff <= nxt_st;
            ctrl_ff <= nxt_ctrl;
            cnt_ff <= nxt_cnt;
            bits_ff <= nxt_bits;
            sh_ff <= nxt_sh;
            data_ff <= nxt_data;
            valid_ff <= nxt_valid;
            cs_ff <= nxt_cs;
            fsp_ff <= nxt_fsp;
            sclk_ff <= nxt_sclk;
            conv_ff <= nxt_conv;
            rdata_ff <= nxt_rdata;
        end
    end

    // In frame-sync mode select stays low; otherwise sync stays high
    assign lnk.cs_n = fs_mode ? 1'b0 : cs_ff;
    assign lnk.frame_sync = fs_mode ? fsp_ff : 1'b1;
    assign lnk.sclk = sclk_ff;
    assign lnk.conv_start = conv_ff;
    assign lnk.power_down_pin = ctrl_ff[CTRL_PDOWN];
    assign rdata = rdata_ff;
endmodule

//--- sim/sar_sva.sv
/*
 Link checker for the converter readout: timing of busy, sdo and power down.
 Assumes it sits beside the link joining host and converter, on mclk.
*/
module sar_sva
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic sclk,
    input wire logic conv_start,
    input wire logic power_down_pin,
    input wire logic busy,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // ----------------
    // Edge history
    // ----------------
    // Edge functions live in a clocked process; a combinational one may not hold them
    logic [4:0] ev_ff;
    logic [5:0] cq_ff;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ev_ff <= 5'h00;
            cq_ff <= 6'h00;
        end
        else
        begin
            ev_ff <= {ev_ff[3:0], $fell(cs_n) | $rose(frame_sync) | $rose(sclk) | $fell(busy)};
            cq_ff <= {cq_ff[4:0], $fell(conv_start) & !cs_n};
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence s_conv_begin;
        $rose(busy);
    endsequence
    sequence s_pd_held;
        power_down_pin [*5];
    endsequence
    AST_CONV_LEN: assert property (s_conv_begin |-> ##[1:46] !busy)
        else $error("conversion ran too long");
    AST_BUSY_CAUSE: assert property (s_conv_begin |-> (|cq_ff))
        else $error("busy rose without a selected start fall");
    AST_SDO_CAUSE: assert property ((sdo_oe && $past(sdo_oe) && $changed(sdo)) |->
        ((|ev_ff[4:1]) || $fell(busy)))
        else $error("sdo moved without a shifting edge");
    AST_PD_OFF: assert property (s_pd_held |-> !sdo_oe)
        else $error("sdo still driven in power down");
    AST_PD_BUSY: assert property (!sdo_oe |-> !busy)
        else $error("busy high while powered down");
    AST_PD_RESUME: assert property ($fell(power_down_pin) |-> ##[1:8] sdo_oe)
        else $error("no resume after power down release");
    AST_READ_IDLE: assert property (($fell(cs_n) || $fell(frame_sync)) |-> !busy)
        else $error("frame started during conversion");
    AST_SCLK_QUIET: assert property (busy |-> $stable(sclk))
        else $error("serial clock moved during conversion");
endmodule

//--- sim/tb_top.sv
/*
 Bench: host and converter joined by one link, plus a second converter
 driven pin by pin for restarts, abort and nap.
 Assumes the hand-over timing of both ends.
*/
module tb_top
    import sar_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, s;
    logic reg_wr = 1'b0, reg_rd = 1'b0, fmt = 1'b0;
    logic [RES_W-1:0] adc1 = '0, adc2 = '0, got2;
    logic [RES_W-1:0] codes [5] = '{18'h3ffff, 18'h20000, 18'h1ffff, 18'h00000, 18'h2aaaa};
    logic nap1, pd1, nap2, pd2;
    int n_fail = 0, n_tests = 0, cyc = 0, i, m;
    sar_if lnk_if ();
    sar_if lnk2_if ();
    sar_dev sar_dev_inst (.mclk(mclk), .nrst(nrst), .lnk(lnk_if.dev), .adc_code(adc1),
        .format_select(fmt), .napping(nap1), .powered_down(pd1));
    sar_host sar_host_inst (.mclk(mclk), .nrst(nrst), .lnk(lnk_if.host), .addr(reg_addr),
        .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd), .rdata(reg_rdata));
    sar_dev sar_dev_inst2 (.mclk(mclk), .nrst(nrst), .lnk(lnk2_if.dev), .adc_code(adc2),
        .format_select(1'b0), .napping(nap2), .powered_down(pd2));
    sar_sva sar_sva_inst (.mclk(mclk), .nrst(nrst), .cs_n(lnk_if.cs_n),
        .frame_sync(lnk_if.frame_sync), .sclk(lnk_if.sclk), .conv_start(lnk_if.conv_start),
        .power_down_pin(lnk_if.power_down_pin), .busy(lnk_if.busy), .sdo(lnk_if.sdo),
        .sdo_oe(lnk_if.sdo_oe));
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 400; k++)
        begin
            reg_read(REG_STAT, s);
            if (s[STAT_ACTIVE] === 1'b0)
                break;
        end
        chk("seq_active", 32'h0, {31'h0, s[STAT_ACTIVE]});
    endtask
    task automatic conv_read(input logic [RES_W-1:0] c, input logic f);
        @(posedge mclk);
        adc1 <= c;
        fmt <= f;
        reg_write(REG_CMD, 32'h1);
        wait_idle();
        reg_write(REG_CMD, 32'h2);
        wait_idle();
        chk("nap1", 1'b0, nap1);
        reg_read(REG_STAT, s);
        chk("valid", 1'b1, s[STAT_VALID]);
        reg_read(REG_DATA, s);
        chk("data", {14'h0, (f ? c ^ 18'h20000 : c)}, s);
        reg_read(REG_STAT, s);
        chk("valid_clr", 1'b0, s[STAT_VALID]);
    endtask
    task automatic wait_busy2(input logic lvl, input int lim, input string nm);
        int k;
        for (k = 0; k < lim && lnk2_if.busy !== lvl; k++)
            tick(1);
        chk(nm, lvl, lnk2_if.busy);
    endtask
    task automatic start2(input logic hold_low);
        lnk2_if.cs_n <= 1'b0;
        tick(4);
        lnk2_if.conv_start <= 1'b0;
        tick(4);
        if (!hold_low)
            lnk2_if.conv_start <= 1'b1;
        wait_busy2(1'b1, 8, "busy2_rise");
    endtask
    // Frame opened by a select fall or a sync pulse; bit taken just before each rise
    task automatic read2(input logic fsm, input int n, output logic [RES_W-1:0] w);
        int k;
        if (fsm)
        begin
            lnk2_if.frame_sync <= 1'b0;
            tick(4);
            lnk2_if.frame_sync <= 1'b1;
            tick(4);
            lnk2_if.frame_sync <= 1'b0;
        end
        else
        begin
            lnk2_if.cs_n <= 1'b1;
            tick(4);
            lnk2_if.cs_n <= 1'b0;
        end
        tick(4);
        w = '0;
        for (k = 0; k < n; k++)
        begin
            lnk2_if.sclk <= 1'b0;
            tick(4);
            w = {w[RES_W-2:0], lnk2_if.sdo};
            lnk2_if.sclk <= 1'b1;
            tick(4);
        end
        if (!fsm)
            lnk2_if.cs_n <= 1'b1;
        tick(4);
    endtask
    // ----------------
    // Sequence
    // ----------------
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        lnk2_if.cs_n = 1'b1;
        lnk2_if.frame_sync = 1'b1;
        lnk2_if.sclk = 1'b1;
        lnk2_if.conv_start = 1'b1;
        lnk2_if.power_down_pin = 1'b0;
        tick(8);
        nrst <= 1'b1;
        reg_write(REG_STAT, 32'h7);
        reg_read(REG_STAT, s);
        chk("stat_rst", 32'h0, s);
        reg_read(4'h2, s);
        chk("unmapped", 32'h0, s);
        $display("test reset done");
        for (m = 0; m < 2; m++)
        begin
            reg_write(REG_CTRL, 32'(m));
            for (i = 0; i < 10; i++)
                conv_read(codes[i / 2], i[0]);
        end
        $display("test coding done");
        reg_write(REG_CTRL, 32'h2);
        tick(10);
        chk("oe_pd", 1'b0, lnk_if.sdo_oe);
        chk("pd_flag", 1'b1, pd1);
        reg_write(REG_CTRL, 32'h0);
        tick(10);
        chk("oe_run", 1'b1, lnk_if.sdo_oe);
        conv_read(18'h2aaaa, 1'b0);
        $display("test power down done");
        lnk2_if.conv_start <= 1'b0;
        tick(10);
        chk("busy2_unsel", 1'b0, lnk2_if.busy);
        lnk2_if.conv_start <= 1'b1;
        adc2 <= 18'h15a5a;
        tick(10);
        start2(1'b0);
        wait_busy2(1'b0, 47, "busy2_fall");
        lnk2_if.cs_n <= 1'b1;
        tick(4);
        read2(1'b0, 5, got2);
        read2(1'b0, 18, got2);
        chk("restart_cs", 32'h15a5a, 32'(got2));
        start2(1'b0);
        tick(8);
        lnk2_if.conv_start <= 1'b0;
        wait_busy2(1'b0, 8, "busy2_abort");
        tick(4);
        lnk2_if.conv_start <= 1'b1;
        read2(1'b0, 18, got2);
        chk("abort_code", 32'h3fc00, 32'(got2));
        $display("test restart and abort done");
        adc2 <= 18'h2d3c5;
        start2(1'b1);
        wait_busy2(1'b0, 47, "busy2_nap");
        tick(7);
        chk("nap2", 1'b1, nap2);
        chk("oe_nap", 1'b1, lnk2_if.sdo_oe);
        lnk2_if.conv_start <= 1'b1;
        tick(8);
        chk("nap2_end", 1'b0, nap2);
        // A full frame leaves sdo low, so the next sync rise has to raise it
        read2(1'b1, 18, got2);
        chk("nap_fs", 32'h2d3c5, 32'(got2));
        lnk2_if.frame_sync <= 1'b0;
        tick(4);
        lnk2_if.frame_sync <= 1'b1;
        adc2 <= 18'h15a5a;
        tick(6);
        chk("fs_msb", 1'b1, lnk2_if.sdo);
        start2(1'b0);
        wait_busy2(1'b0, 47, "busy2_fs");
        tick(6);
        chk("reload_msb", 1'b0, lnk2_if.sdo);
        read2(1'b1, 6, got2);
        read2(1'b1, 18, got2);
        chk("restart_fs", 32'h15a5a, 32'(got2));
        $display("test nap and frame sync done");
        summarize();
    end
endmodule
